// ### common/timer8_cfg.svh
// Register offsets, field positions, count limits and mode codes of the waveform timer
`ifndef TIMER8_CFG_SVH
`define TIMER8_CFG_SVH
`define OFS_CONTROL 12'h000
`define OFS_COUNT 12'h004
`define OFS_COMPARE 12'h008
`define OFS_FLAGS 12'h00c
`define OFS_PIN 12'h010
`define CTL_WAVE_LSB 0
`define CTL_ACTION_LSB 4
`define CTL_TICK_LSB 8
`define FLG_OVF_BIT 0
`define FLG_CMP_BIT 1
`define WS_NORMAL 3'h0
`define WS_PC_FF 3'h1
`define WS_CTC 3'h2
`define WS_FAST_FF 3'h3
`define WS_PC_OCR 3'h5
`define WS_FAST_OCR 3'h7
`define ACT_NONE 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_NONINV 2'h2
`define ACT_INV 2'h3
`define CNT_MAX 8'hff
`define CNT_BOTTOM 8'h00
`define HTRANS_NONSEQ 2'h2
`endif

// ### common/timer8_pkg.sv
// Types of the waveform timer
package timer8_pkg;
  typedef struct packed {
    logic [2:0] waveform_select;
    logic [1:0] output_action_a;
    logic tick_enable;
  } ctrl_t;
  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic pending;
  } bus_phase_t;
  typedef struct packed {
    ctrl_t ctrl;
    logic [7:0] count_value;
    logic count_down;
    logic [7:0] compare_reg_a;
    logic [7:0] compare_buf_a;
    logic wave_out_a;
    logic overflow_flag;
    logic compare_a_flag;
    logic match_pend;
    logic block_match;
    logic port_data;
    logic port_dir;
    bus_phase_t bus;
    logic [31:0] hrdata;
    logic pin_out;
    logic pin_oe;
  } state_t;
endpackage : timer8_pkg

// ### logic/timer8_waveform_modes.sv
// Eight-bit timer waveform generator with AHB-Lite register slave
`timescale 1ns/1ns
`include "timer8_cfg.svh"

module timer8_waveform_modes (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic timer_tick,
  input wire logic pin_in,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic pin_out,
  output logic pin_oe,
  output logic overflow_flag,
  output logic compare_a_flag
);
  timer8_pkg::state_t s_r;
  timer8_pkg::state_t s_nxt;
  logic [1:0] tick_sync_r;
  logic [1:0] pin_sync_r;
  logic tick_prev_r;
  logic tick;
  logic [7:0] top;
  logic pwm_fast;
  logic pwm_pc;
  logic buffered;
  logic wr;
  logic clr_ovf;
  logic clr_cmp;

  // Timer tick is an external strobe; synchronise and take its rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_sync_r <= 2'h0;
      pin_sync_r <= 2'h0;
      tick_prev_r <= 1'b0;
    end else begin
      tick_sync_r <= {tick_sync_r[0], timer_tick};
      pin_sync_r <= {pin_sync_r[0], pin_in};
      tick_prev_r <= tick_sync_r[1];
    end
  end

  always_comb begin
    pwm_fast = (s_r.ctrl.waveform_select == `WS_FAST_FF) || (s_r.ctrl.waveform_select == `WS_FAST_OCR);
    pwm_pc = (s_r.ctrl.waveform_select == `WS_PC_FF) || (s_r.ctrl.waveform_select == `WS_PC_OCR);
    buffered = pwm_fast || pwm_pc;
    top = (s_r.ctrl.waveform_select == `WS_FAST_OCR || s_r.ctrl.waveform_select == `WS_PC_OCR) ?
          s_r.compare_reg_a : `CNT_MAX;
    tick = s_r.ctrl.tick_enable && tick_sync_r[1] && !tick_prev_r;
    wr = s_r.bus.pending && s_r.bus.write;
    clr_ovf = wr && (s_r.bus.addr == `OFS_FLAGS) && hwdata[`FLG_OVF_BIT];
    clr_cmp = wr && (s_r.bus.addr == `OFS_FLAGS) && hwdata[`FLG_CMP_BIT];
  end

  always_comb begin
    logic match;
    logic at_top;
    logic set_ovf;
    logic set_cmp;
    logic [1:0] act;
    match = 1'b0;
    at_top = 1'b0;
    set_ovf = 1'b0;
    set_cmp = 1'b0;
    act = s_r.ctrl.output_action_a;
    s_nxt = s_r;

    // Counter and waveform, advancing on each timer tick
    if (tick) begin
      match = (s_r.count_value == s_r.compare_reg_a) && !s_r.block_match;
      s_nxt.block_match = 1'b0;
      s_nxt.match_pend = match;
      at_top = (s_r.count_value == top);
      if (s_r.match_pend) begin
        set_cmp = 1'b1;
      end
      unique case (s_r.ctrl.waveform_select)
        `WS_NORMAL: begin
          s_nxt.count_value = s_r.count_value + 8'h01;
          set_ovf = (s_r.count_value == `CNT_MAX);
          if (match && act == `ACT_TOGGLE) begin
            s_nxt.wave_out_a = !s_r.wave_out_a;
          end
        end
        `WS_CTC: begin
          if (match) begin
            s_nxt.count_value = `CNT_BOTTOM;
          end else begin
            s_nxt.count_value = s_r.count_value + 8'h01;
          end
          set_ovf = (s_r.count_value == `CNT_MAX);
          if (match && act == `ACT_TOGGLE) begin
            s_nxt.wave_out_a = !s_r.wave_out_a;
          end
        end
        `WS_FAST_FF, `WS_FAST_OCR: begin
          if (at_top) begin
            s_nxt.count_value = `CNT_BOTTOM;
            s_nxt.compare_reg_a = s_r.compare_buf_a;
            set_ovf = 1'b1;
          end else begin
            s_nxt.count_value = s_r.count_value + 8'h01;
          end
          if (act == `ACT_TOGGLE && match) begin
            s_nxt.wave_out_a = !s_r.wave_out_a;
          end else if (act[1]) begin
            // Match wins over bottom except at top with a compare of CNT_MAX, so a zero compare gives a one-tick spike
            if (match && !(at_top && s_r.compare_reg_a == `CNT_MAX)) begin
              s_nxt.wave_out_a = act[0];
            end else if (at_top) begin
              s_nxt.wave_out_a = !act[0];
            end
          end
        end
        `WS_PC_FF, `WS_PC_OCR: begin
          if (at_top && !s_r.count_down) begin
            s_nxt.count_down = 1'b1;
            s_nxt.count_value = s_r.count_value - 8'h01;
            s_nxt.compare_reg_a = s_r.compare_buf_a;
          end else if (s_r.count_down && s_r.count_value == `CNT_BOTTOM) begin
            s_nxt.count_down = 1'b0;
            s_nxt.count_value = s_r.count_value + 8'h01;
          end else if (s_r.count_down) begin
            s_nxt.count_value = s_r.count_value - 8'h01;
          end else begin
            s_nxt.count_value = s_r.count_value + 8'h01;
          end
          set_ovf = s_r.count_down && (s_r.count_value == `CNT_BOTTOM);
          if (act[1]) begin
            if (s_r.count_down && s_r.count_value == `CNT_BOTTOM) begin
              // Bottom forces the up-count state so the period stays symmetric
              s_nxt.wave_out_a = (s_r.compare_reg_a == `CNT_BOTTOM) ? act[0] : !act[0];
            end else if (match && s_r.compare_reg_a != `CNT_MAX) begin
              s_nxt.wave_out_a = s_r.count_down ? !act[0] : act[0];
            end else if (s_r.compare_reg_a == `CNT_MAX) begin
              s_nxt.wave_out_a = !act[0];
            end else if (s_r.compare_reg_a == `CNT_BOTTOM) begin
              s_nxt.wave_out_a = act[0];
            end
          end
        end
        default: begin
          s_nxt.count_value = s_r.count_value;
        end
      endcase
      if (s_r.ctrl.waveform_select == `WS_CTC && match) begin
        set_cmp = 1'b1;
        s_nxt.match_pend = 1'b0;
      end
    end

    // AHB-Lite data phase
    s_nxt.bus.pending = 1'b0;
    if (s_r.bus.pending && s_r.bus.write) begin
      unique case (s_r.bus.addr)
        `OFS_CONTROL: begin
          s_nxt.ctrl.waveform_select = hwdata[`CTL_WAVE_LSB +: 3];
          s_nxt.ctrl.output_action_a = hwdata[`CTL_ACTION_LSB +: 2];
          s_nxt.ctrl.tick_enable = hwdata[`CTL_TICK_LSB];
        end
        `OFS_COUNT: begin
          s_nxt.count_value = hwdata[7:0];
          s_nxt.block_match = 1'b1;
        end
        `OFS_COMPARE: begin
          s_nxt.compare_buf_a = hwdata[7:0];
          if (!buffered) begin
            s_nxt.compare_reg_a = hwdata[7:0];
          end
        end
        `OFS_PIN: begin
          s_nxt.port_data = hwdata[0];
          s_nxt.port_dir = hwdata[1];
        end
        default: begin
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    s_nxt.overflow_flag = set_ovf || (s_r.overflow_flag && !clr_ovf);
    s_nxt.compare_a_flag = set_cmp || (s_r.compare_a_flag && !clr_cmp);

    if (hsel && hready && htrans == `HTRANS_NONSEQ) begin
      s_nxt.bus.pending = 1'b1;
      s_nxt.bus.write = hwrite;
      s_nxt.bus.addr = haddr[11:0];
      s_nxt.hrdata = 32'h0000_0000;
      if (!hwrite) begin
        unique case (haddr[11:0])
          `OFS_CONTROL: begin
            s_nxt.hrdata[`CTL_WAVE_LSB +: 3] = s_nxt.ctrl.waveform_select;
            s_nxt.hrdata[`CTL_ACTION_LSB +: 2] = s_nxt.ctrl.output_action_a;
            s_nxt.hrdata[`CTL_TICK_LSB] = s_nxt.ctrl.tick_enable;
          end
          `OFS_COUNT: s_nxt.hrdata[7:0] = s_nxt.count_value;
          `OFS_COMPARE: s_nxt.hrdata[7:0] = s_nxt.compare_buf_a;
          `OFS_FLAGS: begin
            s_nxt.hrdata[`FLG_OVF_BIT] = s_nxt.overflow_flag;
            s_nxt.hrdata[`FLG_CMP_BIT] = s_nxt.compare_a_flag;
          end
          `OFS_PIN: s_nxt.hrdata[3:0] = {pin_sync_r[1], s_nxt.wave_out_a, s_nxt.port_dir, s_nxt.port_data};
          default: s_nxt.hrdata = 32'h0000_0000;
        endcase
      end
    end

    // Port override: wave output replaces port data when an action is set
    s_nxt.pin_oe = s_nxt.port_dir;
    s_nxt.pin_out = (s_nxt.ctrl.output_action_a != `ACT_NONE) ? s_nxt.wave_out_a : s_nxt.port_data;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hrdata = s_r.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign pin_out = s_r.pin_out;
  assign pin_oe = s_r.pin_oe;
  assign overflow_flag = s_r.overflow_flag;
  assign compare_a_flag = s_r.compare_a_flag;

  a_ctc_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && s_r.ctrl.waveform_select == `WS_CTC && s_r.count_value == s_r.compare_reg_a && !s_r.block_match
     && !(s_r.bus.pending && s_r.bus.write && s_r.bus.addr == `OFS_COUNT)) |=> s_r.count_value == `CNT_BOTTOM)
    else $error("Counter not cleared on match");
  a_ctc_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && s_r.ctrl.waveform_select == `WS_CTC && s_r.count_value == s_r.compare_reg_a && !s_r.block_match)
    |=> s_r.compare_a_flag)
    else $error("Compare flag not set at top");
  a_ctc_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && s_r.ctrl.waveform_select == `WS_CTC && s_r.ctrl.output_action_a == `ACT_TOGGLE
     && s_r.count_value == s_r.compare_reg_a && !s_r.block_match) |=> s_r.wave_out_a != $past(s_r.wave_out_a))
    else $error("Wave output did not toggle");
  a_pin_dir: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 pin_oe == $past(s_nxt.port_dir))
    else $error("Pin enable does not follow direction");
  a_ovf_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && s_r.ctrl.waveform_select == `WS_CTC && s_r.count_value == `CNT_MAX) |=> overflow_flag)
    else $error("Overflow flag missing at wrap");
  a_fast_top: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && s_r.ctrl.waveform_select == `WS_FAST_FF && s_r.count_value == `CNT_MAX && !wr)
    |=> s_r.count_value == `CNT_BOTTOM && overflow_flag)
    else $error("Fast mode did not restart at top");
  a_pc_turn: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && s_r.ctrl.waveform_select == `WS_PC_FF && s_r.count_value == `CNT_MAX && !s_r.count_down && !wr)
    |=> s_r.count_down && s_r.count_value == 8'hfe)
    else $error("Phase correct did not reverse at top");
  a_pc_bottom: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && pwm_pc && s_r.count_down && s_r.count_value == `CNT_BOTTOM) |=> overflow_flag && !s_r.count_down)
    else $error("Overflow flag missing at bottom");
  a_action_none: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_r.ctrl.output_action_a == `ACT_NONE && !wr) |=> $stable(s_r.wave_out_a))
    else $error("Wave output moved with no action");
  a_fast_ovf: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && pwm_fast && s_r.count_value == top) |=> overflow_flag)
    else $error("Fast mode overflow flag missing at top");
  a_pwm_buffer: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr && s_r.bus.addr == `OFS_COMPARE && buffered && !tick) |=> s_r.compare_reg_a == $past(s_r.compare_reg_a))
    else $error("Buffered compare changed outside top or bottom");
  a_ctc_direct: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr && s_r.bus.addr == `OFS_COMPARE && !buffered) |=> s_r.compare_reg_a == $past(hwdata[7:0]))
    else $error("Unbuffered compare write did not land");
endmodule : timer8_waveform_modes

// ### bench/timer8_waveform_modes_tb_top.sv
// Self-checking bench of the eight-bit waveform timer
`timescale 1ns/1ns
`include "timer8_cfg.svh"
module timer8_waveform_modes_tb_top;
  logic hclk, hresetn, hsel, hwrite, hready, timer_tick, pin_in;
  logic [31:0] haddr, hwdata, hrdata, rd, tmp, seed;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, pin_out, pin_oe, overflow_flag, compare_a_flag;
  logic ovf, cmpf, blk, w, act;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int c, ocr, hi;

  timer8_waveform_modes uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .timer_tick(timer_tick), .pin_in(pin_in),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_out(pin_out), .pin_oe(pin_oe),
    .overflow_flag(overflow_flag), .compare_a_flag(compare_a_flag)
  );

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic close_out();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // Hang guard, well above the length of the whole sequence
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One single word transfer; read data lands in rd
  task automatic bus(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= `HTRANS_NONSEQ;
    haddr <= {20'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask : bus

  // Timer clock pulses, two cycles high, then time for the sync and the update
  task automatic tick(int n);
    repeat (n) begin
      @(posedge hclk) timer_tick <= 1'b1;
      repeat (2) @(posedge hclk);
      timer_tick <= 1'b0;
      repeat (5) @(posedge hclk);
      hi += (pin_out === 1'b1);
    end
  endtask : tick

  // Clear-on-match model stepped once per timer clock
  task automatic ctc_ticks(int n);
    repeat (n) begin
      tick(1);
      if (!blk && c == ocr) begin
        c = 0;
        cmpf = 1'b1;
        w = act ? ~w : w;
      end else begin
        if (c == 255) ovf = 1'b1;
        c = (c + 1) % 256;
      end
      blk = 1'b0;
      bus(1'b0, `OFS_COUNT, 32'h0);
      chk("count", rd, 32'(c));
      chk("overflow", overflow_flag, ovf);
      chk("compare flag", compare_a_flag, cmpf);
      if (act) chk("wave", pin_out, w);
    end
  endtask : ctc_ticks

  // High time of the pin over n ticks after n ticks of settling
  task automatic duty(logic [31:0] ctl, logic [7:0] k, int n, int e);
    bus(1'b1, `OFS_COUNT, 32'h0);
    bus(1'b1, `OFS_CONTROL, ctl);
    bus(1'b1, `OFS_COMPARE, {24'h0, k});
    tick(n);
    hi = 0;
    tick(n);
    chk("duty", hi, e);
  endtask : duty

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hready = 1'b1;
    timer_tick = 1'b0;
    pin_in = 1'b0;
    seed = 32'h7;
    {ovf, cmpf, blk, w, act} = 5'h0;
    c = 0;
    hi = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `OFS_CONTROL, 32'h0);
    chk("control reset", rd, 32'h0);
    bus(1'b0, 12'h020, 32'h0);
    chk("unmapped", rd, 32'h0);
    for (int i = 0; i < 6; i++) begin
      tmp = xs();
      pin_in <= tmp[0];
      bus(1'b1, `OFS_PIN, {30'h0, tmp[2:1]});
      bus(1'b0, `OFS_PIN, 32'h0);
      chk("pin in", rd[3], tmp[0]);
      chk("pin drive", pin_oe, tmp[2]);
      chk("port data", pin_out, tmp[1]);
    end
    bus(1'b1, `OFS_PIN, 32'h2);
    bus(1'b1, `OFS_CONTROL, 32'h112);
    act = 1'b1;
    ocr = 5;
    bus(1'b1, `OFS_COMPARE, 32'h5);
    bus(1'b1, `OFS_COUNT, 32'h0);
    blk = 1'b1;
    ctc_ticks(14);
    bus(1'b1, `OFS_FLAGS, 32'h3);
    {ovf, cmpf} = 2'h0;
    // Compare written below the count: the match is missed until after the wrap
    bus(1'b1, `OFS_COUNT, 32'h80);
    c = 128;
    blk = 1'b1;
    ocr = 16;
    bus(1'b1, `OFS_COMPARE, 32'h10);
    ctc_ticks(150);
    bus(1'b1, `OFS_CONTROL, 32'h102);
    act = 1'b0;
    ctc_ticks(20);
    bus(1'b0, `OFS_PIN, 32'h0);
    chk("wave held", rd[2], w);
    bus(1'b1, `OFS_CONTROL, 32'h104);
    bus(1'b0, `OFS_COUNT, 32'h0);
    tmp = rd;
    tick(4);
    bus(1'b0, `OFS_COUNT, 32'h0);
    chk("reserved hold", rd, tmp);
    duty(32'h123, 8'h00, 256, 1);
    duty(32'h123, 8'hff, 256, 256);
    duty(32'h123, 8'h40, 256, 65);
    duty(32'h133, 8'h40, 256, 191);
    duty(32'h117, 8'h03, 80, 40);
    duty(32'h121, 8'h00, 510, 0);
    duty(32'h121, 8'hff, 510, 510);
    duty(32'h121, 8'h40, 510, 128);
    duty(32'h131, 8'h40, 510, 382);
    close_out();
  end
endmodule : timer8_waveform_modes_tb_top
